// File: fbci_pkg.sv
/*
 * Constants and types for the host-side controller of a boot-block
 * flash part: command bytes, bus widths, strobe timing counts.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none

package fbci_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_IDENTIFY = 8'h90;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_NS = 60;
    localparam int RECOVER_NS = 30;
    localparam int READ_NS = 80;
    localparam logic [3:0] STROBE_CYC =
        4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RECOVER_CYC =
        4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] READ_CYC =
        4'((READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        FBCI_OP_READ,
        FBCI_OP_PROGRAM,
        FBCI_OP_ERASE,
        FBCI_OP_READ_ARRAY,
        FBCI_OP_IDENTIFY
    } fbci_op_t;
endpackage

`default_nettype wire

// File: fbci_host.sv
/*
 * Host-side controller driving the flash pins: chip select, output
 * enable, write strobe, width select, address and a split data bus.
 * Assumes the part samples on strobe edges; the program supply level is
 * raised by the controller itself on the data cycle, and no unlock pin is driven.
 */
`default_nettype none

// Summary of operation
// RULE1: erase is setup byte 20H then confirm D0H, supply at program level.
// RULE2: program is setup byte 40H then one data cycle with supply raised.
// RULE3: after program or erase, write FFH before expecting array data.
// RULE4: device shows identification on high-voltage line or identify command.
// RULE5: identification reads hold all other address lines low but bit zero.
// RULE6: device returns maker code at bit zero low, device code when high.
// RULE7: device code differs between top and bottom boot variants.
// RULE8: word width id reads drive upper byte; byte width floats it.
// RULE9: boot block changes only with reset high voltage or unlock high.
// RULE10: other blocks need only normal reset level and program supply.
// RULE11: byte-width data cycle uses bits 0-7 and bit-15 pin as address.
// RULE12: device internal engine completes operations without more strobes.
// RULE13: erase touches only the addressed block.
// RULE14: reset low clears status, floats outputs, enters power-down.
// RULE15: width select low makes bit-15 pin the low byte address.
// RULE16: command bytes go only on data bits 0 to 7.
// RULE17: chip select high floats data; select and output enable low reads.
// RULE18: host writes with select low, output enable high, strobe pulsed.
module fbci_host
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire fbci_pkg::fbci_op_t req_op,
    input wire logic [fbci_pkg::ADDR_W-1:0] req_addr,
    input wire logic [fbci_pkg::DATA_W-1:0] req_wdata,
    input wire logic req_byte_mode,
    input wire logic req_byte_hi,
    output logic rsp_valid,
    output logic [fbci_pkg::DATA_W-1:0] rsp_rdata,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic width_word,
    output logic reset_powerdown_n,
    output logic program_supply_level,
    output logic id_line_high,
    output logic [fbci_pkg::ADDR_W-1:0] addr,
    input wire logic [fbci_pkg::DATA_W-1:0] dq_in,
    output logic [fbci_pkg::DATA_W-1:0] dq_out,
    output logic [fbci_pkg::DATA_W-1:0] dq_oe
);
    import fbci_pkg::*;

    typedef enum logic [2:0] {
        FBCI_IDLE,
        FBCI_WSTROBE,
        FBCI_WRECOVER,
        FBCI_RSTROBE,
        FBCI_DONE
    } fbci_state_t;

    fbci_state_t state, next_state;
    fbci_op_t op, next_op;
    logic second, next_second;
    logic [3:0] cnt, next_cnt;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dq_out, next_dq_oe, next_rdata;
    logic next_width_word, next_vpp, next_id, next_rsp;
    logic next_cs_n, next_oe_n, next_we_n;
    logic [ADDR_W-1:0] a_q;
    logic [DATA_W-1:0] d_q;
    logic b_q, bh_q;

    // command bytes sit on the low lane only; upper lanes stay released
    function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] c);
        cmd_word = {8'h00, c}; // RULE16
    endfunction
    function automatic logic [DATA_W-1:0] read_oe(input logic bm);
        read_oe = bm ? 16'h8000 : 16'h0000; // RULE15
    endfunction

    assign req_ready = (state == FBCI_IDLE) && ce && !sys_rst;
    assign reset_powerdown_n = !sys_rst; // RULE14

    always_comb begin
        next_state = state;
        next_op = op;
        next_second = second;
        next_cnt = cnt;
        next_addr = addr;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        next_rdata = rsp_rdata;
        next_width_word = width_word;
        next_vpp = program_supply_level;
        next_id = id_line_high;
        next_rsp = 1'b0;
        next_cs_n = chip_sel_n;
        next_oe_n = out_en_n;
        next_we_n = write_n;
        case (state)
            FBCI_IDLE: begin
                if (req_valid) begin
                    next_op = req_op;
                    next_second = 1'b0;
                    next_width_word = !req_byte_mode;
                    next_cs_n = 1'b0; // RULE18
                    next_cnt = STROBE_CYC;
                    case (req_op)
                        FBCI_OP_READ: begin
                            next_addr = req_addr;
                            next_oe_n = 1'b0; // RULE17
                            next_dq_out = {req_byte_hi, 15'h0000}; // RULE15
                            next_dq_oe = read_oe(req_byte_mode);
                            next_cnt = READ_CYC;
                            next_state = FBCI_RSTROBE;
                        end
                        FBCI_OP_PROGRAM: begin
                            next_addr = req_addr;
                            next_dq_out = cmd_word(CMD_PROG_SETUP); // RULE2
                            next_dq_oe = {8'h00, 8'hFF};
                            next_we_n = 1'b0;
                            next_state = FBCI_WSTROBE;
                        end
                        FBCI_OP_ERASE: begin
                            next_addr = req_addr;
                            next_dq_out = cmd_word(CMD_ERASE_SETUP); // RULE1
                            next_dq_oe = {8'h00, 8'hFF};
                            next_we_n = 1'b0;
                            next_state = FBCI_WSTROBE;
                        end
                        default: begin
                            next_addr = req_addr;
                            next_dq_out = (req_op == FBCI_OP_IDENTIFY) ?
                                cmd_word(CMD_IDENTIFY) :
                                cmd_word(CMD_READ_ARRAY); // RULE3
                            next_dq_oe = {8'h00, 8'hFF};
                            next_we_n = 1'b0;
                            next_state = FBCI_WSTROBE;
                        end
                    endcase
                end
            end
            FBCI_WSTROBE: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    next_we_n = 1'b1;
                    next_cs_n = 1'b1;
                    next_cnt = RECOVER_CYC;
                    next_state = FBCI_WRECOVER;
                end
            end
            FBCI_WRECOVER: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else if (!second && (op == FBCI_OP_PROGRAM ||
                                         op == FBCI_OP_ERASE)) begin
                    next_second = 1'b1;
                    next_vpp = 1'b1; // RULE1 RULE2
                    next_cs_n = 1'b0;
                    next_we_n = 1'b0;
                    next_cnt = STROBE_CYC;
                    next_state = FBCI_WSTROBE;
                    if (op == FBCI_OP_ERASE) begin
                        next_dq_out = cmd_word(CMD_ERASE_CONFIRM); // RULE1
                    end else if (b_q) begin
                        // RULE11 RULE15
                        next_dq_out = {bh_q, 7'h00, d_q[7:0]};
                        next_dq_oe = {1'b1, 7'h00, 8'hFF};
                    end else begin
                        next_dq_out = d_q;
                        next_dq_oe = '1;
                    end
                end else if (!second && op == FBCI_OP_IDENTIFY) begin
                    next_second = 1'b1;
                    next_id = 1'b1; // RULE4
                    next_dq_out = {bh_q, 15'h0000};
                    next_dq_oe = read_oe(b_q);
                    next_cs_n = 1'b0;
                    next_oe_n = 1'b0;
                    next_addr = {17'h00000, a_q[0]}; // RULE5
                    next_cnt = READ_CYC;
                    next_state = FBCI_RSTROBE;
                end else begin
                    next_dq_oe = '0;
                    next_vpp = 1'b0;
                    next_rsp = 1'b1;
                    next_state = FBCI_IDLE;
                end
            end
            FBCI_RSTROBE: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    // RULE8: upper lane is ignored in byte width
                    next_rdata = width_word ? dq_in : {8'h00, dq_in[7:0]};
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_id = 1'b0;
                    next_dq_oe = '0;
                    next_rsp = 1'b1;
                    next_state = FBCI_DONE;
                end
            end
            default: begin
                next_state = FBCI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= FBCI_IDLE;
            op <= FBCI_OP_READ;
            second <= 1'b0;
            cnt <= 4'h0;
            addr <= '0;
            dq_out <= '0;
            dq_oe <= '0;
            rsp_rdata <= '0;
            width_word <= 1'b1;
            program_supply_level <= 1'b0;
            id_line_high <= 1'b0;
            rsp_valid <= 1'b0;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_n <= 1'b1;
            a_q <= '0;
            d_q <= '0;
            b_q <= 1'b0;
            bh_q <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            op <= next_op;
            second <= next_second;
            cnt <= next_cnt;
            addr <= next_addr;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            rsp_rdata <= next_rdata;
            width_word <= next_width_word;
            program_supply_level <= next_vpp;
            id_line_high <= next_id;
            rsp_valid <= next_rsp;
            chip_sel_n <= next_cs_n;
            out_en_n <= next_oe_n;
            write_n <= next_we_n;
            if (req_ready && req_valid) begin
                a_q <= req_addr;
                d_q <= req_wdata;
                b_q <= req_byte_mode;
                bh_q <= req_byte_hi;
            end
        end
    end

    a_strobe_excl: assert property (@(posedge clk) disable iff (sys_rst)
        !write_n |-> out_en_n && !chip_sel_n) // RULE18
        else $error("write strobe with output enable or no select");
    a_read_float: assert property (@(posedge clk) disable iff (sys_rst)
        !out_en_n |-> dq_oe == read_oe(!width_word)) // RULE17
        else $error("host drives data during read");
    a_cmd_lane: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && !second) |-> dq_oe[15:8] == 8'h00) // RULE16
        else $error("command on upper lanes");
    a_erase_conf: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && second && op == FBCI_OP_ERASE) |->
        dq_out[7:0] == CMD_ERASE_CONFIRM && program_supply_level) // RULE1
        else $error("bad erase confirm");
    a_prog_setup: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && !second && op == FBCI_OP_PROGRAM) |->
        dq_out[7:0] == CMD_PROG_SETUP) // RULE2
        else $error("bad program setup");
    a_vpp_second: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && second) |-> program_supply_level) // RULE2
        else $error("data cycle without program supply");
    a_read_array: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && op == FBCI_OP_READ_ARRAY) |->
        dq_out[7:0] == CMD_READ_ARRAY) // RULE3
        else $error("bad read array byte");
    a_id_addr: assert property (@(posedge clk) disable iff (sys_rst)
        id_line_high |-> addr[ADDR_W-1:1] == '0) // RULE5
        else $error("id read with high address lines");
    a_byte_lane: assert property (@(posedge clk) disable iff (sys_rst)
        (!write_n && second && !width_word) |->
        dq_oe[14:8] == 7'h00) // RULE11
        else $error("byte cycle drives middle lanes");
    c_erase: cover property (@(posedge clk)
        !write_n && second && op == FBCI_OP_ERASE);
    c_prog: cover property (@(posedge clk)
        !write_n && second && op == FBCI_OP_PROGRAM);
    c_id: cover property (@(posedge clk) id_line_high && !out_en_n);
    c_read: cover property (@(posedge clk) rsp_valid && op == FBCI_OP_READ);
endmodule

`default_nettype wire

// File: fbci_flash_model.sv
/* flash part model on the pins of fbci_host: sparse array, id codes.
   assumes strobes are sampled on the host clock. */
`default_nettype none
module fbci_flash_model #(
    parameter logic [7:0] MAKER = 8'h5A, // arbitrary
    parameter logic [7:0] UPPER = 8'h3C, // arbitrary
    parameter logic [7:0] DEV_T = 8'hC3, // arbitrary
    parameter logic [7:0] DEV_B = 8'hC4, // arbitrary
    parameter bit TOP = 1
) (
    input wire logic clk,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic word,
    input wire logic rp_n,
    input wire logic vpp,
    input wire logic id_hi,
    input wire logic [17:0] addr,
    input wire logic [15:0] dout,
    input wire logic [15:0] oe,
    output logic [15:0] dq,
    output logic [7:0] errs
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DEV = TOP ? DEV_T : DEV_B;
    logic [15:0] mem [int];
    logic [15:0] last = 16'h0, d, rv, w, msk;
    logic [17:0] a;
    logic [1:0] mode = 0, pend = 0;
    logic wl = 1;
    wire boot = a[17:13] == 5'h1F;
    wire rd = rp_n && !cs_n && !oe_n && we_n;
    always_comb begin
        rv = 16'h0080;
        msk = rd ? (word ? 16'hFFFF : 16'h00FF) : 16'h0;
        if (mode == 1 || id_hi) begin
            rv = {UPPER, addr[0] ? DEV : MAKER};
        end else if (mode == 0) begin
            rv = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
            if (!word && dq[15]) rv[7:0] = rv[15:8];
        end
    end
    // released bits show the inverse of the last level
    assign dq = (oe & dout) | (~oe & msk & rv) | (~oe & ~msk & ~last);
    initial errs = 0;
    always @(posedge clk) begin
        last <= dq;
        wl <= we_n;
        if (!we_n && !cs_n) begin
            a <= addr;
            d <= dq;
        end
        if (!rp_n) begin
            mode <= 0;
            pend <= 0;
        end else if (we_n && !wl) begin
            pend <= 0;
            if (pend == 2) begin
                mode <= 2;
                w = mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
                if (word) w = d;
                else w[d[15]*8 +: 8] = d[7:0];
                if (!vpp) errs <= errs + 1;
                else if (!boot) mem[int'(a)] = w;
            end else if (pend == 1) begin
                mode <= 2;
                if (d[7:0] != 8'hD0 || !vpp) errs <= errs + 1;
                else if (!boot) begin
                    for (int k = 0; k < 8192; k++)
                        mem.delete(int'({a[17:13], 13'(k)}));
                end
            end else begin
                case (d[7:0])
                    8'h20: pend <= 1;
                    8'h10, 8'h40: pend <= 2;
                    8'hFF: mode <= 0;
                    8'h90: mode <= 1;
                    default: errs <= errs + 1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
/* self-checking bench for fbci_host against fbci_flash_model.
   assumes the host answers every op with one rsp_valid pulse. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbci_pkg::*;
    // arbitrary identification codes
    localparam logic [7:0] MK = 8'hA6, UP = 8'h3C, DV = 8'hC3;
    logic clk = 0, sys_rst = 1, req_valid = 0, bm = 0, bh = 0;
    logic req_ready, rsp_valid, cs_n, oe_n, we_n, ww, rp_n, vpp, idh;
    fbci_op_t req_op = FBCI_OP_READ;
    logic [17:0] req_addr = 0, addr, ad;
    logic [15:0] req_wdata = 0, rsp_rdata, dq_in, dq_out, dq_oe, rd, r;
    logic [7:0] errs;
    logic [15:0] sh [int];
    logic [17:0] q [$];
    int failures = 0, checks_done = 0, cyc = 0;
    always #5 clk = ~clk;
    fbci_host i_fbci_host (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_mode(bm),
        .req_byte_hi(bh), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .chip_sel_n(cs_n), .out_en_n(oe_n), .write_n(we_n),
        .width_word(ww), .reset_powerdown_n(rp_n),
        .program_supply_level(vpp), .id_line_high(idh), .addr(addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    fbci_flash_model #(.MAKER(MK), .UPPER(UP), .DEV_T(DV), .TOP(1))
    i_fbci_flash_model (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .word(ww), .rp_n(rp_n), .vpp(vpp), .id_hi(idh), .addr(addr),
        .dout(dq_out), .oe(dq_oe), .dq(dq_in), .errs(errs));
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] ex(input logic [17:0] a);
        return sh.exists(int'(a)) ? sh[int'(a)] : 16'hFFFF;
    endfunction
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the request stands until the edge that takes it
    task automatic op(input fbci_op_t o, input logic [17:0] a,
                      input logic [15:0] w, input logic b, input logic h);
        req_op <= o;
        req_addr <= a;
        req_wdata <= w;
        bm <= b;
        bh <= h;
        req_valid <= 1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
        rd = rsp_rdata;
    endtask
    task automatic readall();
        op(FBCI_OP_READ_ARRAY, 0, 0, 0, 0);
        foreach (q[k]) begin
            op(FBCI_OP_READ, q[k], 0, 0, 0);
            chk(rd, ex(q[k]));
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        r = 16'hE7D0;
        repeat (5) @(posedge clk);
        chk({cs_n, we_n, rp_n, vpp, dq_oe[11:0]}, 16'hC000);
        sys_rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            op(FBCI_OP_IDENTIFY, 18'(i & 1), 0, i[1], 0);
            chk(rd, {i[1] ? 8'h00 : UP, i[0] ? DV : MK});
        end
        $display("identify test done");
        for (int i = 0; i < 12; i++) begin
            r = nx(r);
            ad = i == 0 ? 18'h0 : i == 1 ? 18'h3DFFF : {2'b00, r};
            r = nx(r);
            op(FBCI_OP_PROGRAM, ad, r, 0, 0);
            sh[int'(ad)] = r;
            q.push_back(ad);
        end
        readall();
        $display("program test done");
        r = nx(r);
        op(FBCI_OP_PROGRAM, 18'h2ABCD, {8'h00, r[7:0]}, 1, 1);
        sh[int'(18'h2ABCD)] = {r[7:0], 8'hFF};
        op(FBCI_OP_READ_ARRAY, 0, 0, 0, 0);
        op(FBCI_OP_READ, 18'h2ABCD, 0, 1, 1);
        chk(rd, {8'h00, r[7:0]});
        op(FBCI_OP_READ, 18'h2ABCD, 0, 1, 0);
        chk(rd, 16'h00FF);
        $display("byte test done");
        op(FBCI_OP_ERASE, q[2], 0, 0, 0);
        foreach (q[k])
            if (q[k][17:13] == q[2][17:13]) sh.delete(int'(q[k]));
        readall();
        $display("erase test done");
        op(FBCI_OP_PROGRAM, 18'h3FFF0, 16'h1234, 0, 0);
        op(FBCI_OP_READ_ARRAY, 0, 0, 0, 0);
        op(FBCI_OP_READ, 18'h3FFF0, 0, 0, 0);
        chk(rd, 16'hFFFF);
        chk({8'h00, errs}, 16'h0000);
        $display("boot block test done");
        give_verdict();
    end
endmodule
`default_nettype wire
